// ---- scae_top.sv ----
// How it works
// - Under auto-enable, transmit needs clear-to-send and receive needs carrier detect.
// - Bit 5 of the receiver control register turns auto-enable on.
// - Clear-to-send falling under auto-enable stops the transmitter by itself.
// - Clear-to-send returning lets the transmitter send again without software.
// - Writing the carrier-generate port drives each channel's carrier output.
// - The generated carrier loops back to carrier detect and enables receive.
// - Bit 1 of the transmit control register drives request-to-send.
// - Request-to-send strapped to clear-to-send enables transmit under auto-enable.
// - Ports decode at base B0 with switches 1, 3, 4 and 8 closed.
// - Counter control word 55 selects counting; next byte is the time constant.
// - Time constant six with divide-by-16 gives 9600 bit rate.
// - The vector register stores the written vector, C7 giving restart zero.
// - Byte 14 to register 0 resets external status and points at register 4.
// - Value 4C in the format register selects x16, no parity, two stops.
// - Value 41 in the receiver register sets seven bits and enables receive.
// - Value AA in the transmit register raises DTR, RTS and enables transmit.
// - Value 18 in the interrupt register selects interrupt on every character.
// - Carrier port bits 0 to 3 drive channels A to D; one is on.
// - Reading the carrier port returns inverted data-set-ready of channels A to D.
`timescale 1ns/1ps
module scae_top
  import scae_pkg::*;
#(
  parameter int unsigned REF_DIV_P = REF_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scae_pins_t pins,
  output scae_modem_t modem
);
  localparam logic [7:0] REF_LAST = 8'(REF_DIV_P - 1);

  scae_state_t st_reg;
  scae_state_t st_next;
  scae_pins_t pins_s;

  scae_sync #(.W($bits(scae_pins_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins),
    .q(pins_s)
  );

  logic [3:0] port;
  logic [1:0] ch;
  logic hit;
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic is_ctrl;
  logic is_data;
  logic is_ct;
  logic is_car;
  logic [7:0] wbyte;
  logic ref_tick;
  logic [3:0] auto_v;

  assign port = paddr[5:2];
  assign ch = port[2:1];
  assign wbyte = pwdata[7:0];
  assign is_ctrl = !port[3] && port[0];
  assign is_data = !port[3] && !port[0];
  assign is_ct = port[3] && !port[2];
  assign is_car = (port == PORT_CARRIER) || (port == PORT_CARRIER_ALT);
  // Upper address bits must match the board base; C and D stay free for others
  assign hit = (paddr[ADDR_W-1:10] == '0) && (paddr[9:6] == BASE_NIB)
    && (paddr[1:0] == 2'h0) && (port != PORT_FREE0) && (port != PORT_FREE1);
  assign setup = psel && !penable;
  assign access = psel && penable && st_reg.pready;
  assign wr_acc = access && pwrite && hit;
  assign rd_acc = access && !pwrite && hit;
  assign ref_tick = (st_reg.ref_cnt == REF_LAST);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      auto_v[i] = st_reg.rx_ctrl[i][AUTO_BIT];
    end
  end

  function automatic logic [5:0] div_limit(input logic [1:0] sel);
    unique case (sel)
      CLK_X1: div_limit = LIM_X1;
      CLK_X16: div_limit = LIM_X16;
      CLK_X32: div_limit = LIM_X32;
      default: div_limit = LIM_X64;
    endcase
  endfunction

  function automatic logic [7:0] read_val(input scae_state_t s, input logic [3:0] p,
                                          input scae_pins_t ps);
    logic [1:0] c;
    c = p[2:1];
    read_val = 8'h00;
    if (!p[3] && p[0]) begin
      if (s.ptr[c] == PTR_VECTOR) begin
        read_val = s.int_vec[c];
      end else begin
        read_val = {2'h0, ps.cts[c], 1'b0, ps.dcd[c], s.tx_allow[c], s.ext[c],
                    s.rx_allow[c]};
      end
    end else if (p[3] && !p[2]) begin
      read_val = s.count[p[1:0]][7:0];
    end else if (p[3] && p[2] && p[1]) begin
      read_val = {4'h0, ~ps.dsr};
    end
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.ct_tick = '0;
    st_next.bit_tick = '0;
    // One reference tick every REF_DIV_P clocks stands in for the baud reference
    st_next.ref_cnt = ref_tick ? 8'h00 : st_reg.ref_cnt + 8'h01;

    // Read data is captured in the setup cycle so pready can come from a flop
    if (setup) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !hit;
      st_next.prdata = {24'h000000, read_val(st_reg, port, pins_s)};
    end else if (access) begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
    end

    if (rd_acc && is_ctrl) begin
      st_next.ptr[ch] = PTR_BASE;
    end

    if (wr_acc && is_ctrl) begin
      if (st_reg.ptr[ch] == PTR_BASE) begin
        st_next.ptr[ch] = wbyte[2:0];
        if (wbyte[CMD_HI:CMD_LO] == CMD_RST_EXT) begin
          st_next.ext[ch] = 1'b0;
        end
      end else begin
        // Pointer 6 or 7 names no register: the byte is dropped
        unique case (st_reg.ptr[ch])
          PTR_INT_CTRL: st_next.int_ctrl[ch] = wbyte;
          PTR_VECTOR: st_next.int_vec[ch] = wbyte;
          PTR_RX_CTRL: st_next.rx_ctrl[ch] = wbyte;
          PTR_FMT_CTRL: st_next.fmt_ctrl[ch] = wbyte;
          PTR_TX_CTRL: st_next.tx_ctrl[ch] = wbyte;
          default: st_next.ptr[ch] = PTR_BASE;
        endcase
        st_next.ptr[ch] = PTR_BASE;
      end
    end

    if (wr_acc && is_car) begin
      st_next.carrier = wbyte[3:0];
    end

    for (int k = 0; k < 4; k++) begin
      if (wr_acc && is_ct && port[1:0] == 2'(k)) begin
        if (st_reg.tc_next[k]) begin
          st_next.time_constant[k] = wbyte;
          // A time constant of zero counts 256 reference ticks
          st_next.count[k] = {wbyte == 8'h00, wbyte};
          st_next.tc_next[k] = 1'b0;
          st_next.running[k] = 1'b1;
        end else if (wbyte[CT_CTRL_BIT]) begin
          st_next.tc_next[k] = wbyte[CT_TC_NEXT_BIT];
        end
      end else if (st_reg.running[k] && ref_tick) begin
        if (st_reg.count[k] == 9'h001) begin
          st_next.count[k] = {st_reg.time_constant[k] == 8'h00, st_reg.time_constant[k]};
          st_next.ct_tick[k] = 1'b1;
        end else begin
          st_next.count[k] = st_reg.count[k] - 9'h001;
        end
      end
    end

    for (int c = 0; c < 4; c++) begin
      st_next.prev_cts[c] = pins_s.cts[c];
      st_next.prev_dcd[c] = pins_s.dcd[c];
      // A modem change in the clearing cycle stays latched
      if ((pins_s.cts[c] != st_reg.prev_cts[c]) || (pins_s.dcd[c] != st_reg.prev_dcd[c])) begin
        st_next.ext[c] = 1'b1;
      end
      if (st_reg.ct_tick[CH_SRC[c]]) begin
        if (st_reg.div_cnt[c] >= div_limit(st_reg.fmt_ctrl[c][CLK_HI:CLK_LO])) begin
          st_next.div_cnt[c] = 6'h00;
          st_next.bit_tick[c] = 1'b1;
        end else begin
          st_next.div_cnt[c] = st_reg.div_cnt[c] + 6'h01;
        end
      end
      // Modem outputs use this cycle's writes so they move one edge after them
      st_next.rts[c] = st_next.tx_ctrl[c][RTS_BIT];
      st_next.dtr[c] = st_next.tx_ctrl[c][DTR_BIT];
      st_next.tx_allow[c] = st_next.tx_ctrl[c][TX_EN_BIT]
        && (!st_next.rx_ctrl[c][AUTO_BIT] || pins_s.cts[c]);
      st_next.rx_allow[c] = st_next.rx_ctrl[c][RX_EN_BIT]
        && (!st_next.rx_ctrl[c][AUTO_BIT] || pins_s.dcd[c]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign modem.rts = st_reg.rts;
  assign modem.dtr = st_reg.dtr;
  assign modem.carrier = st_reg.carrier;
  assign modem.tx_allow = st_reg.tx_allow;
  assign modem.rx_allow = st_reg.rx_allow;
  assign modem.bit_tick = st_reg.bit_tick;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_tx_gate: assert property (
    (auto_v & ~pins_s.cts) != 4'h0
    |=> (st_reg.tx_allow & auto_v & $past(auto_v & ~pins_s.cts)) == 4'h0)
    else $error("transmit allowed without clear-to-send");
  a_rx_gate: assert property (
    (auto_v & ~pins_s.dcd) != 4'h0
    |=> (st_reg.rx_allow & auto_v & $past(auto_v & ~pins_s.dcd)) == 4'h0)
    else $error("receive allowed without carrier detect");
  a_cts_stop: assert property (
    $fell(pins_s.cts[0]) && auto_v[0] && !wr_acc |=> !st_reg.tx_allow[0])
    else $error("transmitter not stopped on clear-to-send loss");
  a_cts_resume: assert property (
    $rose(pins_s.cts[0]) && auto_v[0] && st_reg.tx_ctrl[0][TX_EN_BIT] && !wr_acc
    |=> st_reg.tx_allow[0])
    else $error("transmitter not resumed on clear-to-send");
  a_carrier_out: assert property (
    wr_acc && is_car |=> st_reg.carrier == $past(pwdata[3:0]) ##1 modem.carrier == $past(pwdata[3:0], 2))
    else $error("carrier output does not follow write");
  a_rts_out: assert property (
    wr_acc && is_ctrl && st_reg.ptr[ch] == PTR_TX_CTRL && ch == 2'h0
    |=> modem.rts[0] == $past(pwdata[RTS_BIT]))
    else $error("request-to-send does not follow register");
  a_ptr_select: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] == PTR_BASE
    |=> st_reg.ptr[0] == $past(pwdata[2:0]))
    else $error("pointer not loaded");
  a_ptr_return: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] != PTR_BASE |=> st_reg.ptr[0] == PTR_BASE)
    else $error("pointer did not return to base");
  a_tc_load: assert property (
    wr_acc && is_ct && port[1:0] == 2'h0 && st_reg.tc_next[0]
    |=> st_reg.running[0] && st_reg.time_constant[0] == $past(pwdata[7:0]))
    else $error("time constant not taken");
  a_dsr_read: assert property (
    setup && !pwrite && hit && is_car |=> st_reg.prdata[3:0] == ~$past(pins_s.dsr))
    else $error("carrier port read wrong");

  // Auto-enable and status
  a_manual_tx: assert property (
    !auto_v[0] && !wr_acc |=> st_reg.tx_allow[0] == $past(st_reg.tx_ctrl[0][TX_EN_BIT]))
    else $error("transmitter gated while auto-enable is off");
  a_auto_on: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] == PTR_RX_CTRL
    |=> auto_v[0] == $past(pwdata[AUTO_BIT]))
    else $error("auto-enable does not follow receiver control bit");
  a_rx_carrier: assert property (
    auto_v[0] && st_reg.rx_ctrl[0][RX_EN_BIT] && pins_s.dcd[0] && !wr_acc
    |=> st_reg.rx_allow[0])
    else $error("receiver not enabled by carrier detect");
  a_status_read: assert property (
    setup && hit && is_ctrl && ch == 2'h0 && st_reg.ptr[0] != PTR_VECTOR
    |=> st_reg.prdata[0] == $past(st_reg.rx_allow[0]))
    else $error("status does not show receive enable");

  // Register writes and pointer
  a_int_store: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] == PTR_INT_CTRL
    |=> st_reg.int_ctrl[0] == $past(pwdata[7:0]))
    else $error("interrupt control register not written");
  a_vec_store: assert property (
    wr_acc && is_ctrl && ch == 2'h1 && st_reg.ptr[1] == PTR_VECTOR
    |=> st_reg.int_vec[1] == $past(pwdata[7:0]))
    else $error("vector register not written");
  a_vec_read: assert property (
    setup && hit && is_ctrl && ch == 2'h1 && st_reg.ptr[1] == PTR_VECTOR
    |=> st_reg.prdata[7:0] == $past(st_reg.int_vec[1]))
    else $error("vector register not read back");
  a_fmt_store: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] == PTR_FMT_CTRL
    |=> st_reg.fmt_ctrl[0] == $past(pwdata[7:0]))
    else $error("format register not written");
  a_rx_store: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] == PTR_RX_CTRL
    |=> st_reg.rx_ctrl[0] == $past(pwdata[7:0]))
    else $error("receiver control register not written");
  a_dtr_out: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] == PTR_TX_CTRL
    |=> modem.dtr[0] == $past(pwdata[DTR_BIT]))
    else $error("terminal-ready does not follow register");
  a_ext_clear: assert property (
    wr_acc && is_ctrl && ch == 2'h0 && st_reg.ptr[0] == PTR_BASE
    && pwdata[CMD_HI:CMD_LO] == CMD_RST_EXT && pins_s.cts[0] == st_reg.prev_cts[0]
    && pins_s.dcd[0] == st_reg.prev_dcd[0] |=> !st_reg.ext[0])
    else $error("external status flag not cleared");
  a_ext_set: assert property (
    pins_s.cts[0] != st_reg.prev_cts[0] || pins_s.dcd[0] != st_reg.prev_dcd[0]
    |=> st_reg.ext[0])
    else $error("modem change not latched");
  a_rd_ptr_clear: assert property (
    rd_acc && is_ctrl && ch == 2'h0 |=> st_reg.ptr[0] == PTR_BASE)
    else $error("pointer not cleared by status read");

  // Bus answer and port decode
  a_miss_err: assert property (
    setup && !hit |=> pready && pslverr)
    else $error("unmapped access not refused");
  a_data_quiet: assert property (
    setup && hit && is_data |=> pready && !pslverr)
    else $error("data port access refused");
  a_miss_ignored: assert property (
    psel && penable && pwrite && !hit |=> $stable(st_reg.carrier) && $stable(st_reg.ptr))
    else $error("unmapped write changed state");

  // Baud chain
  a_tc_ctrl: assert property (
    wr_acc && is_ct && port[1:0] == 2'h0 && !st_reg.tc_next[0] && pwdata[CT_CTRL_BIT]
    |=> st_reg.tc_next[0] == $past(pwdata[CT_TC_NEXT_BIT]))
    else $error("control word did not arm time constant");
  a_ct_tick: assert property (
    st_reg.running[0] && ref_tick && st_reg.count[0] == 9'h001
    && !(wr_acc && is_ct && port[1:0] == 2'h0) |=> st_reg.ct_tick[0])
    else $error("counter did not pulse at end of count");
  a_x16_tick: assert property (
    st_reg.ct_tick[0] && st_reg.fmt_ctrl[0][CLK_HI:CLK_LO] == CLK_X16
    && st_reg.div_cnt[0] == LIM_X16 |=> modem.bit_tick[0])
    else $error("bit tick missing after sixteen counter pulses");

  c_cts_stop: cover property ($fell(st_reg.tx_allow[0]) && auto_v[0]);
  c_carrier_rx: cover property (st_reg.carrier[0] && st_reg.rx_allow[0] && auto_v[0]);
  c_tc_load: cover property (wr_acc && is_ct && st_reg.tc_next[0]);
  c_bit_tick: cover property (st_reg.bit_tick[0]);
  c_cts_resume: cover property ($rose(st_reg.tx_allow[0]) && auto_v[0]);
endmodule // scae_top

// ---- scae_pkg.sv ----
package scae_pkg;

  localparam int unsigned PCLK_HZ = 100_000_000;
  localparam int unsigned REF_HZ = 921_600;
  // Baud reference ticks derived from pclk, counted down by the counter-timers
  localparam int unsigned REF_DIV = PCLK_HZ / REF_HZ;

  localparam int ADDR_W = 12;
  // Port index = byte address / 4; switches 1, 3, 4 and 8 closed give base B0
  localparam logic [3:0] BASE_NIB = 4'hB;
  localparam logic [3:0] PORT_CARRIER = 4'hE;
  localparam logic [3:0] PORT_CARRIER_ALT = 4'hF;
  localparam logic [3:0] PORT_FREE0 = 4'hC;
  localparam logic [3:0] PORT_FREE1 = 4'hD;

  localparam logic [2:0] PTR_BASE = 3'h0;
  localparam logic [2:0] PTR_INT_CTRL = 3'h1;
  localparam logic [2:0] PTR_VECTOR = 3'h2;
  localparam logic [2:0] PTR_RX_CTRL = 3'h3;
  localparam logic [2:0] PTR_FMT_CTRL = 3'h4;
  localparam logic [2:0] PTR_TX_CTRL = 3'h5;

  localparam int RX_EN_BIT = 0;
  localparam int AUTO_BIT = 5;
  localparam int TX_EN_BIT = 3;
  localparam int RTS_BIT = 1;
  localparam int DTR_BIT = 7;
  localparam int CMD_HI = 5;
  localparam int CMD_LO = 3;
  localparam logic [2:0] CMD_RST_EXT = 3'h2;
  localparam int CLK_HI = 7;
  localparam int CLK_LO = 6;
  localparam logic [1:0] CLK_X1 = 2'h0;
  localparam logic [1:0] CLK_X16 = 2'h1;
  localparam logic [1:0] CLK_X32 = 2'h2;
  localparam logic [5:0] LIM_X1 = 6'h00;
  localparam logic [5:0] LIM_X16 = 6'h0F;
  localparam logic [5:0] LIM_X32 = 6'h1F;
  localparam logic [5:0] LIM_X64 = 6'h3F;

  localparam int CT_CTRL_BIT = 0;
  localparam int CT_TC_NEXT_BIT = 2;
  // Counter-timer feeding each serial channel: A-0, B-1, C-2, D-2
  localparam logic [3:0][1:0] CH_SRC = {2'h2, 2'h2, 2'h1, 2'h0};

  typedef struct packed {
    logic [3:0] cts;
    logic [3:0] dcd;
    logic [3:0] dsr;
  } scae_pins_t;

  typedef struct packed {
    logic [3:0] rts;
    logic [3:0] dtr;
    logic [3:0] carrier;
    logic [3:0] tx_allow;
    logic [3:0] rx_allow;
    logic [3:0] bit_tick;
  } scae_modem_t;

  typedef struct packed {
    logic [3:0][7:0] int_ctrl;
    logic [3:0][7:0] int_vec;
    logic [3:0][7:0] rx_ctrl;
    logic [3:0][7:0] fmt_ctrl;
    logic [3:0][7:0] tx_ctrl;
    logic [3:0][2:0] ptr;
    logic [3:0] ext;
    logic [3:0] prev_cts;
    logic [3:0] prev_dcd;
    logic [3:0] carrier;
    logic [3:0] rts;
    logic [3:0] dtr;
    logic [3:0] tx_allow;
    logic [3:0] rx_allow;
    logic [3:0] bit_tick;
    logic [3:0][5:0] div_cnt;
    logic [3:0][7:0] time_constant;
    logic [3:0][8:0] count;
    logic [3:0] tc_next;
    logic [3:0] running;
    logic [3:0] ct_tick;
    logic [7:0] ref_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scae_state_t;

  localparam scae_state_t STATE_RESET = '0;

endpackage

// ---- scae_sync.sv ----
`timescale 1ns/1ps
module scae_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scae_sync_t;

  scae_sync_t st_reg;
  scae_sync_t st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule // scae_sync

// ---- scae_peer.sv ----
`timescale 1ns/1ps
module scae_peer
  import scae_pkg::*;
(
  input wire scae_modem_t modem,
  input wire logic [3:0] buffer_full,
  input wire logic [3:0] dsr_on,
  output scae_pins_t pins
);
  // Request-to-send strapped to clear-to-send, gated by a full printer buffer
  assign pins.cts = modem.rts & ~buffer_full;
  // Generated carrier looped back to carrier detect
  assign pins.dcd = modem.carrier;
  assign pins.dsr = dsr_on;
endmodule // scae_peer

// ---- serial_channel_auto_enable_tb.sv ----
`timescale 1ns/1ps
module serial_channel_auto_enable_tb
  import scae_pkg::*;
;
  localparam int RD = 2;
  localparam logic [11:0] CA = 12'h2C4;
  localparam logic [11:0] CB = 12'h2CC;
  localparam logic [11:0] CT0 = 12'h2E0;
  localparam logic [11:0] CG = 12'h2F8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] full = '0;
  logic [3:0] dsr = '0;
  scae_pins_t pins;
  scae_modem_t modem;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int cmp_count = 0;
  int p;
  logic [7:0] init_seq [8] = '{8'h14, 8'h4C, 8'h03, 8'h41, 8'h05, 8'hAA, 8'h01, 8'h18};

  always #5 pclk = ~pclk;

  scae_top #(.REF_DIV_P(RD)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .modem(modem));

  scae_peer peer (.modem(modem), .buffer_full(full), .dsr_on(dsr), .pins(pins));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles between two successive bit ticks of channel A
  task automatic tick_gap(output int g);
    int n;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      n = 1;
      while (modem.bit_tick[0] !== 1'b1 && n < 1000) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 1000) begin
        miscompares++;
        conclude();
      end
    end
    g = n;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("modem after reset", modem, '0);
    foreach (init_seq[i]) xfer(CA, 1'b1, init_seq[i]);
    repeat (5) @(posedge pclk);
    chk("rts dtr tx rx", {modem.rts[0], modem.dtr[0], modem.tx_allow[0], modem.rx_allow[0]},
      4'hF);
    xfer(CT0, 1'b1, 8'h55);
    xfer(CT0, 1'b1, 8'h06);
    tick_gap(p);
    chk("bit period", p, 6 * 16 * RD);
    xfer(CB, 1'b1, 8'h02);
    xfer(CB, 1'b1, 8'hC7);
    xfer(CB, 1'b1, 8'h02);
    xfer(CB, 1'b0, 8'h00);
    chk("vector", rd, 32'h0000_00C7);
    xfer(CB, 1'b0, 8'h00);
    chk("status after pointer return", rd, 32'h0);
    xfer(CA, 1'b1, 8'h03);
    xfer(CA, 1'b1, 8'h61);
    repeat (5) @(posedge pclk);
    chk("rx gated by carrier", modem.rx_allow[0], 1'b0);
    chk("tx via strap", modem.tx_allow[0], 1'b1);
    full[0] <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("tx stopped", modem.tx_allow[0], 1'b0);
    full[0] <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("tx resumed", modem.tx_allow[0], 1'b1);
    xfer(CG, 1'b1, 8'h01);
    repeat (5) @(posedge pclk);
    chk("rx via carrier", {modem.carrier[0], modem.rx_allow[0]}, 2'h3);
    xfer(CA, 1'b0, 8'h00);
    chk("status ext set", rd, 32'h2F);
    xfer(CA, 1'b1, 8'h10);
    xfer(CA, 1'b0, 8'h00);
    chk("status ext clear", rd, 32'h2D);
    xfer(CG, 1'b1, 8'h0A);
    repeat (2) @(posedge pclk);
    chk("carrier bits", modem.carrier, 4'hA);
    dsr <= 4'h5;
    repeat (4) @(posedge pclk);
    xfer(CG, 1'b0, 8'h00);
    chk("dsr read", rd, 32'h0000_000A);
    chk("dsr read error", err, 1'b0);
    xfer(CG + 12'h4, 1'b0, 8'h00);
    chk("dsr read alt", rd, 32'h0A);
    xfer(12'h2F0, 1'b0, 8'h00);
    chk("unused port", err, 1'b1);
    xfer(12'h0C4, 1'b1, 8'h05);
    chk("off base", err, 1'b1);
    xfer(12'h2C0, 1'b0, 8'h00);
    chk("data port read", rd, 32'h0);
    chk("data port error", err, 1'b0);
    conclude();
  end

  initial begin
    repeat (50000) @(posedge pclk);
    miscompares++;
    conclude();
  end
endmodule // serial_channel_auto_enable_tb
